/* src/bip_pkg.sv */
// constants and types shared by the boot init and port select logic
package bip_pkg;

    // clock and timing figures
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_PG_LOW_NS = 4000;      // least low time that counts as power loss
    localparam int T_PG_HIGH_NS = 625;      // least high time before power good is believed
    localparam int T_PWR_LEAD_NS = 1000;    // power indicator leads init complete by this
    localparam int T_PULSE_NS = 1000;       // width of each error pulse
    localparam int T_GAP_NS = 1000;         // gap between the two error pulses

    // least times round up to whole cycles
    localparam int CYC_PG_LOW = (T_PG_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_PG_HIGH = (T_PG_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_PWR_LEAD = (T_PWR_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_PULSE = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_GAP = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // counter widths and terminal values
    localparam int FILT_W = 10;
    localparam int TIMER_W = 8;
    localparam logic [FILT_W-1:0] FILT_LOW_LAST = FILT_W'(CYC_PG_LOW - 1);
    localparam logic [FILT_W-1:0] FILT_HIGH_LAST = FILT_W'(CYC_PG_HIGH - 1);
    localparam logic [TIMER_W-1:0] TMR_LEAD_LAST = TIMER_W'(CYC_PWR_LEAD - 1);
    localparam logic [TIMER_W-1:0] TMR_PULSE_LAST = TIMER_W'(CYC_PULSE - 1);
    localparam logic [TIMER_W-1:0] TMR_GAP_LAST = TIMER_W'(CYC_GAP - 1);

    // internal memory under test
    localparam int RAM_DEPTH = 16;
    localparam int RAM_AW = 4;
    localparam int RAM_DW = 8;
    localparam logic [RAM_AW-1:0] RAM_LAST = RAM_AW'(RAM_DEPTH - 1);
    localparam logic [RAM_DW-1:0] RAM_CLEAR_VAL = 8'h00;
    localparam logic [RAM_DW-1:0] RAM_TEST_SEED = 8'ha5;

    // host port slave addresses, chosen by the select pin
    localparam logic [7:0] HOST_ADDR_LOW_WR = 8'h34;
    localparam logic [7:0] HOST_ADDR_LOW_RD = 8'h35;
    localparam logic [7:0] HOST_ADDR_HIGH_WR = 8'h3a;
    localparam logic [7:0] HOST_ADDR_HIGH_RD = 8'h3b;

    // init sequencer states
    typedef enum logic [3:0] {
        ST_HELD = 4'h0,
        ST_CLEAR = 4'h1,
        ST_WRITE = 4'h2,
        ST_CHECK = 4'h3,
        ST_LOAD = 4'h4,
        ST_LEAD = 4'h5,
        ST_RUN = 4'h6,
        ST_ERR_LEAD = 4'h7,
        ST_ERR_PULSE1 = 4'h8,
        ST_ERR_GAP = 4'h9,
        ST_ERR_PULSE2 = 4'ha,
        ST_HALT = 4'hb
    } bip_state_type;

    // system status word
    typedef struct packed {
        logic done;       // sequence finished, pass or fail
        logic test_pass;  // memory test passed
        logic test_fail;  // memory test failed
    } bip_status_type;

    // host port slave address pair
    typedef struct packed {
        logic [7:0] write_addr;
        logic [7:0] read_addr;
    } bip_addr_type;

    // roles of the two serial ports
    typedef struct packed {
        logic host_port_is_slave;
        logic peripheral_port_is_master;
    } bip_roles_type;

endpackage

/* src/bip_ram.sv */
// flip-flop internal memory with a defect input for exercising the test
`timescale 1ns/1ps
module bip_ram (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic we_i,
    input wire logic [bip_pkg::RAM_AW-1:0] addr_i,
    input wire logic [bip_pkg::RAM_DW-1:0] wdata_i,
    input wire logic defect_i,
    output logic [bip_pkg::RAM_DW-1:0] rdata_o
);
    import bip_pkg::*;

    logic [RAM_DW-1:0] mem_reg [RAM_DEPTH];   // storage words
    logic [RAM_DW-1:0] mem_next [RAM_DEPTH];  // next value per word

    // one entry per word; write only the addressed one
    genvar gi;
    generate
        for (gi = 0; gi < RAM_DEPTH; gi++) begin : g_word
            always_comb begin
                mem_next[gi] = mem_reg[gi];
                if (we_i && (addr_i == RAM_AW'(gi))) begin
                    mem_next[gi] = wdata_i;
                end
            end

            always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    mem_reg[gi] <= '0;
                end else begin
                    mem_reg[gi] <= mem_next[gi];
                end
            end
        end
    endgenerate

    // defect models a bit stuck at one so the failing path can be reached
    assign rdata_o = mem_reg[addr_i] | {{(RAM_DW-1){1'b0}}, defect_i};

endmodule

/* src/bip_boot_init.sv */
// power-up init sequencer: memory test, ready signalling, address select
`timescale 1ns/1ps

module bip_boot_init (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic power_good_input_i,
    input wire logic addr_sel_pin_i,
    output logic addr_sel_pin_o,
    output logic addr_sel_pin_oe_n_o,
    input wire logic gpio_out_i,
    input wire logic gpio_oe_i,
    output logic gpio_in_o,
    output logic flash_load_req_o,
    input wire logic flash_load_done_i,
    input wire logic ram_defect_i,
    output logic power_on_indicator_o,
    output logic gpio_line_twenty_six_o,
    output logic gpio_line_twenty_six_oe_n_o,
    output bip_pkg::bip_status_type status_o,
    output bip_pkg::bip_addr_type host_addr_o,
    output bip_pkg::bip_roles_type port_roles_o
);
    import bip_pkg::*;

    // bounds used by the checks below
    localparam int A_GAP_MAX = CYC_GAP + 2;
    localparam int A_LEAD = CYC_PWR_LEAD;

    // pin synchronisers; first stages read only by second stages
    logic pg_meta_reg;
    logic pg_sync_reg;
    logic sel_meta_reg;
    logic sel_sync_reg;

    // power good filter state
    logic pg_ok_reg;
    logic pg_ok_next;
    logic [FILT_W-1:0] filt_reg;
    logic [FILT_W-1:0] filt_next;

    // sequencer state
    bip_state_type state_reg;
    bip_state_type state_next;
    logic [RAM_AW-1:0] idx_reg;
    logic [RAM_AW-1:0] idx_next;
    logic [TIMER_W-1:0] timer_reg;
    logic [TIMER_W-1:0] timer_next;
    bip_status_type status_reg;
    bip_status_type status_next;
    logic sel_reg;          // captured select level
    logic sel_next;
    logic sampled_reg;      // select has been captured
    logic sampled_next;
    logic pwr_reg;          // power indicator
    logic pwr_next;
    logic done_reg;         // init complete line
    logic done_next;

    // released pin drive, registered so the pad sees clean levels
    logic pin_out_reg;
    logic pin_out_next;
    logic pin_oe_n_reg;
    logic pin_oe_n_next;
    logic gpio_in_reg;
    logic gpio_in_next;
    logic released;

    // memory access
    logic ram_we;
    logic [RAM_DW-1:0] ram_wdata;
    logic [RAM_DW-1:0] ram_rdata;
    logic [RAM_DW-1:0] pattern;

    // address dependent pattern catches stuck and shorted address bits
    assign pattern = RAM_TEST_SEED ^ {{(RAM_DW-RAM_AW){1'b0}}, idx_reg};

    bip_ram bip_ram_i (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .we_i(ram_we),
        .addr_i(idx_reg),
        .wdata_i(ram_wdata),
        .defect_i(ram_defect_i),
        .rdata_o(ram_rdata)
    );

    // two flip-flop synchronisers for the asynchronous pins
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pg_meta_reg <= 1'b0;
            pg_sync_reg <= 1'b0;
            sel_meta_reg <= 1'b0;
            sel_sync_reg <= 1'b0;
        end else begin
            pg_meta_reg <= power_good_input_i;
            pg_sync_reg <= pg_meta_reg;
            sel_meta_reg <= addr_sel_pin_i;
            sel_sync_reg <= sel_meta_reg;
        end
    end

    // power good filter: long low drops, shorter high restores
    // the asymmetry rejects glitches yet leaves reset promptly
    always_comb begin
        pg_ok_next = pg_ok_reg;
        filt_next = '0;
        if (pg_sync_reg != pg_ok_reg) begin
            filt_next = filt_reg + FILT_W'(1);
            if (pg_ok_reg && (filt_reg == FILT_LOW_LAST)) begin
                pg_ok_next = 1'b0;
                filt_next = '0;
            end else if (!pg_ok_reg && (filt_reg == FILT_HIGH_LAST)) begin
                pg_ok_next = 1'b1;
                filt_next = '0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pg_ok_reg <= 1'b0;
            filt_reg <= '0;
        end else begin
            pg_ok_reg <= pg_ok_next;
            filt_reg <= filt_next;
        end
    end

    // init sequencer next state
    always_comb begin
        state_next = state_reg;
        idx_next = idx_reg;
        timer_next = timer_reg;
        status_next = status_reg;
        sel_next = sel_reg;
        sampled_next = sampled_reg;
        pwr_next = pwr_reg;
        done_next = done_reg;
        ram_we = 1'b0;
        ram_wdata = RAM_CLEAR_VAL;
        if (!pg_ok_reg) begin
            // power not good: everything back to its reset value
            state_next = ST_HELD;
            idx_next = '0;
            timer_next = '0;
            status_next = '0;
            sel_next = 1'b0;
            sampled_next = 1'b0;
            pwr_next = 1'b0;
            done_next = 1'b0;
        end else begin
            case (state_reg)
                ST_HELD: begin
                    // select is captured once, on the way out of reset
                    sel_next = sel_sync_reg;
                    sampled_next = 1'b1;
                    idx_next = '0;
                    state_next = ST_CLEAR;
                end
                ST_CLEAR: begin
                    ram_we = 1'b1;
                    ram_wdata = RAM_CLEAR_VAL;
                    idx_next = idx_reg + RAM_AW'(1);
                    if (idx_reg == RAM_LAST) begin
                        state_next = ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    // check the cleared word, then lay the pattern down
                    ram_we = 1'b1;
                    ram_wdata = pattern;
                    idx_next = idx_reg + RAM_AW'(1);
                    if (ram_rdata != RAM_CLEAR_VAL) begin
                        status_next.test_fail = 1'b1;
                        // indicator rises with the failure so the lead equals the pass path
                        pwr_next = 1'b1;
                        timer_next = '0;
                        state_next = ST_ERR_LEAD;
                    end else if (idx_reg == RAM_LAST) begin
                        state_next = ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    idx_next = idx_reg + RAM_AW'(1);
                    if (ram_rdata != pattern) begin
                        status_next.test_fail = 1'b1;
                        pwr_next = 1'b1;
                        timer_next = '0;
                        state_next = ST_ERR_LEAD;
                    end else if (idx_reg == RAM_LAST) begin
                        status_next.test_pass = 1'b1;
                        state_next = ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    // code copy is done outside; wait for its answer
                    if (flash_load_done_i) begin
                        timer_next = '0;
                        pwr_next = 1'b1;
                        state_next = ST_LEAD;
                    end
                end
                ST_LEAD: begin
                    timer_next = timer_reg + TIMER_W'(1);
                    if (timer_reg == TMR_LEAD_LAST) begin
                        done_next = 1'b1;
                        status_next.done = 1'b1;
                        state_next = ST_RUN;
                    end
                end
                ST_RUN: begin
                    state_next = ST_RUN;
                end
                ST_ERR_LEAD: begin
                    pwr_next = 1'b1;
                    timer_next = timer_reg + TIMER_W'(1);
                    if (timer_reg == TMR_LEAD_LAST) begin
                        timer_next = '0;
                        done_next = 1'b1;
                        state_next = ST_ERR_PULSE1;
                    end
                end
                ST_ERR_PULSE1: begin
                    timer_next = timer_reg + TIMER_W'(1);
                    if (timer_reg == TMR_PULSE_LAST) begin
                        timer_next = '0;
                        done_next = 1'b0;
                        state_next = ST_ERR_GAP;
                    end
                end
                ST_ERR_GAP: begin
                    timer_next = timer_reg + TIMER_W'(1);
                    if (timer_reg == TMR_GAP_LAST) begin
                        timer_next = '0;
                        done_next = 1'b1;
                        state_next = ST_ERR_PULSE2;
                    end
                end
                ST_ERR_PULSE2: begin
                    timer_next = timer_reg + TIMER_W'(1);
                    if (timer_reg == TMR_PULSE_LAST) begin
                        done_next = 1'b0;
                        status_next.done = 1'b1;
                        state_next = ST_HALT;
                    end
                end
                ST_HALT: begin
                    // only a power good cycle or reset leaves here
                    state_next = ST_HALT;
                end
                default: begin
                    state_next = ST_HELD;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_HELD;
            idx_reg <= '0;
            timer_reg <= '0;
            status_reg <= '0;
            sel_reg <= 1'b0;
            sampled_reg <= 1'b0;
            pwr_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            timer_reg <= timer_next;
            status_reg <= status_next;
            sel_reg <= sel_next;
            sampled_reg <= sampled_next;
            pwr_reg <= pwr_next;
            done_reg <= done_next;
        end
    end

    // pin handed over as gpio only after a good init
    assign released = (state_reg == ST_RUN);

    // released pin drive and readback
    always_comb begin
        pin_out_next = 1'b0;
        pin_oe_n_next = 1'b1;   // pin is an input while address is chosen
        gpio_in_next = 1'b0;
        if (released) begin
            pin_out_next = gpio_out_i;
            pin_oe_n_next = !gpio_oe_i;
            gpio_in_next = sel_sync_reg;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_out_reg <= 1'b0;
            pin_oe_n_reg <= 1'b1;
            gpio_in_reg <= 1'b0;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_n_reg <= pin_oe_n_next;
            gpio_in_reg <= gpio_in_next;
        end
    end

    // outputs
    assign addr_sel_pin_o = pin_out_reg;
    assign addr_sel_pin_oe_n_o = pin_oe_n_reg;
    assign gpio_in_o = gpio_in_reg;
    assign flash_load_req_o = (state_reg == ST_LOAD);
    assign power_on_indicator_o = pwr_reg;
    assign gpio_line_twenty_six_o = done_reg;
    assign gpio_line_twenty_six_oe_n_o = 1'b0;          // always driven
    assign status_o = status_reg;
    // address pair rests on the captured level, never the live pin
    assign host_addr_o.write_addr = sel_reg ? HOST_ADDR_HIGH_WR : HOST_ADDR_LOW_WR;
    assign host_addr_o.read_addr = sel_reg ? HOST_ADDR_HIGH_RD : HOST_ADDR_LOW_RD;
    assign port_roles_o.host_port_is_slave = 1'b1;
    assign port_roles_o.peripheral_port_is_master = 1'b1;

    // checks
    property p_load_after_test;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        flash_load_req_o |-> status_reg.test_pass && !status_reg.test_fail;
    endproperty
    a_load_after_test: assert property (p_load_after_test)
        else $error("load requested before a passing memory test");

    property p_status_kept;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (pg_ok_reg && status_reg.test_fail) |=> status_reg.test_fail || !pg_ok_reg;
    endproperty
    a_status_kept: assert property (p_status_kept)
        else $error("test failure lost from status");

    property p_fail_halts;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        status_reg.test_fail |-> !flash_load_req_o && (state_reg != ST_RUN);
    endproperty
    a_fail_halts: assert property (p_fail_halts)
        else $error("failed test still loaded or ran");

    property p_second_pulse;
        @(posedge clk_sys_i) disable iff (sys_rst_i || !pg_ok_reg)
        (status_reg.test_fail && $fell(done_reg) && (state_reg == ST_ERR_GAP))
            |-> ##[1:A_GAP_MAX] done_reg;
    endproperty
    a_second_pulse: assert property (p_second_pulse)
        else $error("second error pulse missing");

    property p_power_leads;
        @(posedge clk_sys_i) disable iff (sys_rst_i || !pg_ok_reg)
        $rose(gpio_line_twenty_six_o) && (state_reg != ST_ERR_PULSE2)
            |-> power_on_indicator_o && $past(pwr_reg, A_LEAD);
    endproperty
    a_power_leads: assert property (p_power_leads)
        else $error("init complete without power indicator lead");

    property p_addr_low;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (sampled_reg && !sel_reg) |-> (host_addr_o.write_addr == 8'h34)
            && (host_addr_o.read_addr == 8'h35);
    endproperty
    a_addr_low: assert property (p_addr_low)
        else $error("wrong slave addresses for low select");

    property p_addr_high;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (sampled_reg && sel_reg) |-> (host_addr_o.write_addr == 8'h3a)
            && (host_addr_o.read_addr == 8'h3b);
    endproperty
    a_addr_high: assert property (p_addr_high)
        else $error("wrong slave addresses for high select");

    property p_sel_frozen;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (sampled_reg && $past(sampled_reg) && pg_ok_reg) |-> $stable(sel_reg);
    endproperty
    a_sel_frozen: assert property (p_sel_frozen)
        else $error("select resampled after capture");

    property p_held_in_reset;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !pg_ok_reg |=> (state_reg == ST_HELD) && !done_reg && !pwr_reg;
    endproperty
    a_held_in_reset: assert property (p_held_in_reset)
        else $error("sequencer ran while power good low");

endmodule

/* verif/bip_flash_model.sv */
// behavioural flash copy engine that answers the load request
`timescale 1ns/1ps
module bip_flash_model (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic load_req_i,
    input wire logic [7:0] delay_i,
    output logic load_done_o
);
    logic [7:0] wait_reg; // cycles spent on the copy so far
    // copy lasts delay_i cycles, then one done pulse; zero delay answers at once
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wait_reg <= 8'h00;
            load_done_o <= 1'b0;
        end else if (load_req_i && !load_done_o) begin
            if (wait_reg >= delay_i) begin
                load_done_o <= 1'b1;
                wait_reg <= 8'h00;
            end else begin
                wait_reg <= wait_reg + 8'h01;
            end
        end else begin
            // request gone or just answered: drop done so it is never seen twice
            load_done_o <= 1'b0;
            wait_reg <= 8'h00;
        end
    end
endmodule

/* verif/boot_init_and_port_select_tb.sv */
// self-checking bench for the power-up init sequencer
`timescale 1ns/1ps
module boot_init_and_port_select_tb;
    import bip_pkg::*;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic pg = 1'b0; // power good pin
    logic sel_drv = 1'b0; // level the board puts on the select pad
    logic gpio_out = 1'b0;
    logic gpio_oe = 1'b0;
    logic defect = 1'b0;
    logic [7:0] delay = 8'h00;
    logic clr = 1'b0; // clears the event monitor's init rise and load request counts
    logic pad, sel_o, sel_oe_n, gpio_in, load_req, load_done, pwr, init, init_oe_n;
    bip_status_type status;
    bip_addr_type host_addr;
    bip_roles_type roles;
    int errors = 0;
    int checked = 0;
    int init_rises, pwr_lead, lead_seen, req_seen;
    logic init_q, pwr_q, pwr_at_rise;

    // pad level: design drives when its enable is low, else the board
    assign pad = sel_oe_n ? sel_drv : sel_o;

    always #2.5 clk_sys_i = ~clk_sys_i;

    bip_boot_init bip_boot_init_i (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .power_good_input_i(pg),
        .addr_sel_pin_i(pad), .addr_sel_pin_o(sel_o), .addr_sel_pin_oe_n_o(sel_oe_n),
        .gpio_out_i(gpio_out), .gpio_oe_i(gpio_oe), .gpio_in_o(gpio_in),
        .flash_load_req_o(load_req), .flash_load_done_i(load_done), .ram_defect_i(defect),
        .power_on_indicator_o(pwr), .gpio_line_twenty_six_o(init),
        .gpio_line_twenty_six_oe_n_o(init_oe_n), .status_o(status),
        .host_addr_o(host_addr), .port_roles_o(roles)
    );

    bip_flash_model bip_flash_model_i (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .load_req_i(load_req),
        .delay_i(delay), .load_done_o(load_done)
    );

    // event monitor: init line rises, indicator lead, load requests
    always @(posedge clk_sys_i) begin
        init_q <= init;
        pwr_q <= pwr;
        pwr_lead <= (pwr && !pwr_q) ? 0 : pwr_lead + 1;
        if (clr) begin
            init_rises <= 0;
            req_seen <= 0;
        end else begin
            if (init && !init_q) begin
                init_rises <= init_rises + 1;
                lead_seen <= pwr_lead;
                pwr_at_rise <= pwr;
            end
            if (load_req) req_seen <= req_seen + 1;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // power loss long enough to reset, then power good again
    task automatic power_cycle(input logic sel, input logic bad);
        pg <= 1'b0;
        sel_drv <= sel;
        defect <= bad;
        gpio_oe <= 1'b0;
        clr <= 1'b1;
        repeat (CYC_PG_LOW + 20) @(posedge clk_sys_i);
        check(16'(status), 16'h0);
        check(16'({init, pwr, load_req}), 16'h0);
        clr <= 1'b0;
        pg <= 1'b1;
    endtask

    // bounded wait on the init line
    task automatic wait_init();
        for (int i = 0; i < 1000 && init !== 1'b1; i++) @(posedge clk_sys_i);
    endtask

    // successful boot with the given select level and copy delay
    task automatic run_pass(input logic sel, input logic [7:0] d);
        logic [15:0] exp_addr;
        exp_addr = sel ? {HOST_ADDR_HIGH_WR, HOST_ADDR_HIGH_RD}
                       : {HOST_ADDR_LOW_WR, HOST_ADDR_LOW_RD};
        power_cycle(sel, 1'b0);
        delay <= d;
        for (int i = 0; i < 600 && load_req !== 1'b1; i++) @(posedge clk_sys_i);
        check(16'(status), 16'h2);
        check(16'(pwr), 16'h0);
        wait_init();
        repeat (2) @(posedge clk_sys_i);
        check(16'(init_rises), 16'h1);
        check(16'(lead_seen + 1), 16'(CYC_PWR_LEAD));
        check(16'(status), 16'h6);
        check(16'(host_addr), exp_addr);
        check(16'(init_oe_n), 16'h0);
        check(16'(roles), 16'h3);
        // released pin now obeys the gpio controls; opposite level must not move addresses
        gpio_oe <= 1'b1;
        gpio_out <= !sel;
        sel_drv <= !sel;
        repeat (6) @(posedge clk_sys_i);
        check(16'({sel_oe_n, sel_o, gpio_in}), 16'({1'b0, !sel, !sel}));
        check(16'(host_addr), exp_addr);
        gpio_oe <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        check(16'({sel_oe_n, gpio_in}), 16'({1'b1, !sel}));
        repeat (700) @(posedge clk_sys_i);
        check(16'({init_rises, init}), 16'({15'h1, 1'b1}));
    endtask

    // memory test failure: halt, two pulses, no code load
    task automatic run_fail();
        power_cycle(1'b0, 1'b1);
        for (int i = 0; i < 600 && status.test_fail !== 1'b1; i++) @(posedge clk_sys_i);
        repeat (CYC_PWR_LEAD + CYC_PULSE * 2 + CYC_GAP + 100) @(posedge clk_sys_i);
        check(16'(init_rises), 16'h2);
        check(16'(pwr_at_rise), 16'h1);
        check(16'(req_seen), 16'h0);
        check(16'(status), 16'h5);
        check(16'({init, sel_oe_n}), 16'h1);
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        errors++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        check(16'(host_addr), 16'h3435);
        check(16'({sel_oe_n, init_oe_n, roles}), 16'hb);
        repeat (300) @(posedge clk_sys_i);
        check(16'({status, init, pwr, load_req}), 16'h0);
        run_pass(1'b0, 8'h00);
        run_pass(1'b1, 8'h40);
        run_fail();
        print_verdict();
    end
endmodule
